//--- hdl/ser_pkg.sv
/*
 * ser_pkg: constants, types and carriers for the status event reporting block.
 * assumes: one 200 MHz clock, APB register access, 32-bit data.
 */
package ser_pkg;
	localparam int unsigned STAT_W = 15;
	localparam int unsigned CODE_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned N_GRP = 2;
	localparam int unsigned Q_DEPTH = 8;
	localparam int unsigned QPTR_W = 3;
	localparam int unsigned QCNT_W = 4;

	// group index
	localparam logic GRP_OPER = 1'b0;
	localparam logic GRP_QUES = 1'b1;

	// byte offsets inside a group, then addresses outside the groups from 8'h40; group base = index * stride
	localparam logic [ADDR_W-1:0] GRP_STRIDE = 8'h20;
	localparam logic [ADDR_W-1:0] REG_COND = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PTR = 8'h04;
	localparam logic [ADDR_W-1:0] REG_NTR = 8'h08;
	localparam logic [ADDR_W-1:0] REG_ENA = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_EVT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PRESET = 8'h40;
	localparam logic [ADDR_W-1:0] REG_QUEUE = 8'h44;
	localparam logic [ADDR_W-1:0] REG_QCOUNT = 8'h48;
	localparam logic [ADDR_W-1:0] GRP_SPAN = 8'h40;

	localparam logic [STAT_W-1:0] PTR_PRESET = 15'h7fff;
	localparam logic [STAT_W-1:0] NTR_PRESET = 15'h0000;
	localparam logic [STAT_W-1:0] ENA_PRESET = 15'h0000;
	localparam logic [STAT_W-1:0] EVT_RESET = 15'h0000;
	localparam logic [CODE_W-1:0] NO_ERROR = 16'h0000;
	localparam logic [QCNT_W-1:0] Q_FULL = 4'h8;
	localparam logic [QCNT_W-1:0] Q_EMPTY = 4'h0;
	localparam logic [QCNT_W-1:0] Q_ONE = 4'h1;
	localparam logic [QPTR_W-1:0] QPTR_ONE = 3'h1;

	typedef logic [N_GRP-1:0][STAT_W-1:0] ser_stat_t;

	typedef enum logic [1:0] {
		SER_BUS_IDLE = 2'b01,
		SER_BUS_ANS = 2'b10
	} ser_bus_e;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [DATA_W-1:0] pwdata;
	} ser_apb_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} ser_apb_rsp_s;

	typedef struct packed {
		logic [STAT_W-1:0] cond_prev;
		logic [STAT_W-1:0] ptr;
		logic [STAT_W-1:0] ntr;
		logic [STAT_W-1:0] ena;
		logic [STAT_W-1:0] evt;
		logic sum;
	} ser_grp_s;

	typedef struct packed {
		ser_grp_s [N_GRP-1:0] grp;
		logic [Q_DEPTH-1:0][CODE_W-1:0] q;
		logic [QPTR_W-1:0] wr;
		logic [QPTR_W-1:0] rd;
		logic [QCNT_W-1:0] cnt;
		logic pop_pend;
		ser_bus_e bus;
		ser_apb_rsp_s rsp;
	} ser_state_s;
endpackage : ser_pkg

//--- hdl/ser_status_event_reporting.sv
/*
 * ser_status_event_reporting: operation and questionable status groups
 * (condition, transition filters, event latch, enable mask, summary) with
 * a preset action and an oldest-first error queue, behind an APB slave.
 * assumes: cond_in and the error push port come from logic on sys_clk;
 * the APB master holds its request until pready.
 */
// Decided for this implementation: the placing of the registers and register access over APB.
// Contract
// - rising condition bit with its rising filter set latches the event bit
// - questionable falling change latches event only if its falling filter is one
// - all-ones rising filter in questionable group catches every rising change
// - preset loads every rising filter with all ones
// - preset clears every falling filter
// - preset clears both enable masks
// - condition read returns live status and changes nothing
// - event read returns latched events then clears them
// - enabled set event raises the group summary bit
// - queue read pops oldest entry; empty queue reads zero
// - queue codes positive for device errors, negative for standard errors
// - every status part is fifteen bits wide for reads and writes
// - only preset reinitialises status parts; apart from it only register writes change filters and masks
`timescale 1ns/1ps
module ser_status_event_reporting (
	input wire logic sys_clk,
	input wire logic rst,
	input wire ser_pkg::ser_apb_req_s apb_req,
	output ser_pkg::ser_apb_rsp_s apb_rsp,
	input wire ser_pkg::ser_stat_t cond_in,
	input wire logic err_push,
	input wire logic err_std,
	input wire logic [ser_pkg::STAT_W-1:0] err_num,
	output logic oper_sum,
	output logic ques_sum
);
	ser_pkg::ser_state_s s_r;
	ser_pkg::ser_state_s s_nxt;
	ser_pkg::ser_stat_t rise;
	ser_pkg::ser_stat_t fall;
	ser_pkg::ser_stat_t new_evt;
	logic cap;
	logic done;
	logic in_grp;
	logic gi;
	logic [ser_pkg::ADDR_W-1:0] off;
	logic push_ok;
	logic pop;
	logic [ser_pkg::CODE_W-1:0] push_code;

	genvar g;
	generate
		for (g = 0; g < ser_pkg::N_GRP; g++) begin : g_trans
			assign rise[g] = cond_in[g] & ~s_r.grp[g].cond_prev;
			assign fall[g] = ~cond_in[g] & s_r.grp[g].cond_prev;
			assign new_evt[g] = (rise[g] & s_r.grp[g].ptr) | (fall[g] & s_r.grp[g].ntr);
		end
	endgenerate

	assign cap = apb_req.psel && apb_req.penable && (s_r.bus == ser_pkg::SER_BUS_IDLE);
	assign done = apb_req.psel && apb_req.penable && (s_r.bus == ser_pkg::SER_BUS_ANS);
	assign in_grp = apb_req.paddr < ser_pkg::GRP_SPAN;
	assign gi = apb_req.paddr >= ser_pkg::GRP_STRIDE;
	assign off = in_grp ? (apb_req.paddr - (gi ? ser_pkg::GRP_STRIDE : '0)) : apb_req.paddr;
	// sign convention: standard errors negative, device errors positive
	assign push_code = err_std ? (ser_pkg::CODE_W)'(-{1'b0, err_num})
		: {1'b0, err_num};
	assign push_ok = err_push && (s_r.cnt != ser_pkg::Q_FULL);
	assign pop = done && !apb_req.pwrite && !in_grp && (off == ser_pkg::REG_QUEUE)
		&& s_r.pop_pend;

	always_comb begin
		s_nxt = s_r;
		// live condition history and summary bits
		for (int i = 0; i < ser_pkg::N_GRP; i++) begin
			s_nxt.grp[i].cond_prev = cond_in[i];
			s_nxt.grp[i].sum = |(s_r.grp[i].evt & s_r.grp[i].ena);
		end
		// bus capture: answer data and pready are registered together, both given one cycle after capture
		if (cap) begin
			s_nxt.bus = ser_pkg::SER_BUS_ANS;
			s_nxt.rsp.pready = 1'b1;
			s_nxt.rsp.pslverr = 1'b0;
			s_nxt.rsp.prdata = '0;
			s_nxt.pop_pend = 1'b0;
			if (in_grp) begin
				unique case (off)
					ser_pkg::REG_COND: s_nxt.rsp.prdata[ser_pkg::STAT_W-1:0] = cond_in[gi];
					ser_pkg::REG_PTR: s_nxt.rsp.prdata[ser_pkg::STAT_W-1:0] = s_r.grp[gi].ptr;
					ser_pkg::REG_NTR: s_nxt.rsp.prdata[ser_pkg::STAT_W-1:0] = s_r.grp[gi].ntr;
					ser_pkg::REG_ENA: s_nxt.rsp.prdata[ser_pkg::STAT_W-1:0] = s_r.grp[gi].ena;
					ser_pkg::REG_EVT: s_nxt.rsp.prdata[ser_pkg::STAT_W-1:0] = s_r.grp[gi].evt;
					default: s_nxt.rsp.pslverr = 1'b1;
				endcase
			end else begin
				unique case (off)
					ser_pkg::REG_PRESET: s_nxt.rsp.prdata = '0;
					ser_pkg::REG_QUEUE: begin
						if (!apb_req.pwrite && s_r.cnt != ser_pkg::Q_EMPTY) begin
							s_nxt.rsp.prdata = {{(ser_pkg::DATA_W-ser_pkg::CODE_W)
								{s_r.q[s_r.rd][ser_pkg::CODE_W-1]}}, s_r.q[s_r.rd]};
							s_nxt.pop_pend = 1'b1;
						end else begin
							s_nxt.rsp.prdata = {{(ser_pkg::DATA_W-ser_pkg::CODE_W){1'b0}},
								ser_pkg::NO_ERROR};
						end
					end
					ser_pkg::REG_QCOUNT: s_nxt.rsp.prdata[ser_pkg::QCNT_W-1:0] = s_r.cnt;
					default: s_nxt.rsp.pslverr = 1'b1;
				endcase
			end
		end
		// completion edge: writes, preset, event clear, queue pop
		if (done) begin
			s_nxt.bus = ser_pkg::SER_BUS_IDLE;
			s_nxt.rsp.pready = 1'b0;
			s_nxt.pop_pend = 1'b0;
			if (apb_req.pwrite && in_grp) begin
				unique case (off)
					ser_pkg::REG_PTR: s_nxt.grp[gi].ptr = apb_req.pwdata[ser_pkg::STAT_W-1:0];
					ser_pkg::REG_NTR: s_nxt.grp[gi].ntr = apb_req.pwdata[ser_pkg::STAT_W-1:0];
					ser_pkg::REG_ENA: s_nxt.grp[gi].ena = apb_req.pwdata[ser_pkg::STAT_W-1:0];
					default: ;
				endcase
			end
			if (apb_req.pwrite && !in_grp && off == ser_pkg::REG_PRESET) begin
				for (int i = 0; i < ser_pkg::N_GRP; i++) begin
					s_nxt.grp[i].ptr = ser_pkg::PTR_PRESET;
					s_nxt.grp[i].ntr = ser_pkg::NTR_PRESET;
					s_nxt.grp[i].ena = ser_pkg::ENA_PRESET;
				end
			end
			// clear only what was reported
			if (!apb_req.pwrite && in_grp && off == ser_pkg::REG_EVT)
				s_nxt.grp[gi].evt = s_r.grp[gi].evt & ~s_r.rsp.prdata[ser_pkg::STAT_W-1:0];
		end
		// new events win over the read clear
		for (int i = 0; i < ser_pkg::N_GRP; i++)
			s_nxt.grp[i].evt = s_nxt.grp[i].evt | new_evt[i];
		// error queue; pushes to a full queue are dropped
		if (push_ok) begin
			s_nxt.q[s_r.wr] = push_code;
			s_nxt.wr = s_r.wr + ser_pkg::QPTR_ONE;
		end
		if (pop)
			s_nxt.rd = s_r.rd + ser_pkg::QPTR_ONE;
		if (push_ok && !pop)
			s_nxt.cnt = s_r.cnt + ser_pkg::Q_ONE;
		else if (pop && !push_ok)
			s_nxt.cnt = s_r.cnt - ser_pkg::Q_ONE;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < ser_pkg::N_GRP; i++) begin
				s_r.grp[i].cond_prev <= '0;
				s_r.grp[i].ptr <= ser_pkg::PTR_PRESET;
				s_r.grp[i].ntr <= ser_pkg::NTR_PRESET;
				s_r.grp[i].ena <= ser_pkg::ENA_PRESET;
				s_r.grp[i].evt <= ser_pkg::EVT_RESET;
				s_r.grp[i].sum <= 1'b0;
			end
			s_r.q <= '0;
			s_r.wr <= '0;
			s_r.rd <= '0;
			s_r.cnt <= ser_pkg::Q_EMPTY;
			s_r.pop_pend <= 1'b0;
			s_r.bus <= ser_pkg::SER_BUS_IDLE;
			s_r.rsp <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp = s_r.rsp;
	assign oper_sum = s_r.grp[ser_pkg::GRP_OPER].sum;
	assign ques_sum = s_r.grp[ser_pkg::GRP_QUES].sum;

	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic preset_wr;
	logic evt_rd;
	assign preset_wr = done && apb_req.pwrite && !in_grp && off == ser_pkg::REG_PRESET;
	assign evt_rd = done && !apb_req.pwrite && in_grp && off == ser_pkg::REG_EVT;

	a_oper_rise_latch: assert property (
		(new_evt[0] != '0) |=> ((s_r.grp[0].evt & $past(new_evt[0])) == $past(new_evt[0])))
		else $error("operation event bit not latched");
	a_ques_hold_evt: assert property (
		(!done && new_evt[1] == '0) |=> (s_r.grp[1].evt == $past(s_r.grp[1].evt)))
		else $error("questionable event changed without filtered transition");
	a_ques_fall_latch: assert property (
		((fall[1] & s_r.grp[1].ntr) != '0)
		|=> ((s_r.grp[1].evt & $past(fall[1] & s_r.grp[1].ntr)) != '0))
		else $error("questionable falling change not latched");
	a_ques_all_rise: assert property (
		(s_r.grp[1].ptr == ser_pkg::PTR_PRESET && rise[1] != '0)
		|=> ((s_r.grp[1].evt & $past(rise[1])) == $past(rise[1])))
		else $error("all-ones rising filter missed a change");
	a_preset_ptr: assert property (
		preset_wr |=> (s_r.grp[0].ptr == ser_pkg::PTR_PRESET
			&& s_r.grp[1].ptr == ser_pkg::PTR_PRESET))
		else $error("preset did not load rising filters");
	a_preset_ntr: assert property (
		preset_wr |=> (s_r.grp[0].ntr == ser_pkg::NTR_PRESET
			&& s_r.grp[1].ntr == ser_pkg::NTR_PRESET))
		else $error("preset did not clear falling filters");
	a_preset_ena: assert property (
		preset_wr |=> (s_r.grp[0].ena == ser_pkg::ENA_PRESET
			&& s_r.grp[1].ena == ser_pkg::ENA_PRESET) ##1 !oper_sum && !ques_sum)
		else $error("preset did not clear enable masks");
	a_cond_live_read: assert property (
		(cap && !apb_req.pwrite && in_grp && off == ser_pkg::REG_COND)
		|=> (apb_rsp.pready && apb_rsp.prdata[ser_pkg::STAT_W-1:0] == $past(cond_in[gi])))
		else $error("condition read not live");
	a_evt_read_clear: assert property (
		evt_rd |=> (s_r.grp[$past(gi)].evt
			== (($past(s_r.grp[gi].evt) & ~$past(apb_rsp.prdata[ser_pkg::STAT_W-1:0]))
			| $past(new_evt[gi]))))
		else $error("event read did not clear reported bits");
	a_oper_summary: assert property (
		((s_r.grp[0].evt & s_r.grp[0].ena) != '0) |=> oper_sum)
		else $error("operation summary not raised");
	a_ques_summary: assert property (
		((s_r.grp[1].evt & s_r.grp[1].ena) == '0) |=> !ques_sum)
		else $error("questionable summary raised without enabled event");
	a_queue_empty_zero: assert property (
		(cap && !apb_req.pwrite && !in_grp && off == ser_pkg::REG_QUEUE
			&& s_r.cnt == ser_pkg::Q_EMPTY) |=> (apb_rsp.prdata == '0 && !s_r.pop_pend))
		else $error("empty queue read not zero");
	a_queue_pop_count: assert property (
		(pop && !push_ok) |=> (s_r.cnt == $past(s_r.cnt) - ser_pkg::Q_ONE))
		else $error("queue read did not remove entry");
	a_code_sign: assert property (
		(push_ok && err_num != '0)
		|=> (s_r.q[$past(s_r.wr)][ser_pkg::CODE_W-1] == $past(err_std)))
		else $error("error code sign wrong");
	a_read_width: assert property (
		(apb_rsp.pready && in_grp) |-> (apb_rsp.prdata[ser_pkg::DATA_W-1:ser_pkg::STAT_W] == '0))
		else $error("status read wider than fifteen bits");
	a_parts_stable: assert property (
		!done |=> ($stable(s_r.grp[0].ptr) && $stable(s_r.grp[1].ntr)
			&& $stable(s_r.grp[1].ena)))
		else $error("status part changed without write or preset");

	// event latching, both groups
	a_ques_rise_latch: assert property (
		((rise[1] & s_r.grp[1].ptr) != '0)
		|=> ((s_r.grp[1].evt & $past(rise[1] & s_r.grp[1].ptr))
			== $past(rise[1] & s_r.grp[1].ptr)))
		else $error("questionable rising change not latched");
	a_oper_no_stray: assert property (
		((s_r.grp[0].evt & ~$past(s_r.grp[0].evt) & ~$past(new_evt[0])) == '0))
		else $error("operation event set without filtered change");
	a_ques_no_stray: assert property (
		((s_r.grp[1].evt & ~$past(s_r.grp[1].evt) & ~$past(new_evt[1])) == '0))
		else $error("questionable event set without filtered change");
	a_ques_fall_blocked: assert property (
		((fall[1] & ~s_r.grp[1].ntr & ~rise[1]) != '0 && !done)
		|=> ((s_r.grp[1].evt & $past(fall[1] & ~s_r.grp[1].ntr))
			== ($past(s_r.grp[1].evt) & $past(fall[1] & ~s_r.grp[1].ntr))))
		else $error("unfiltered falling change altered an event bit");

	// register writes land at the completion edge
	a_ptr_write: assert property (
		(done && apb_req.pwrite && in_grp && off == ser_pkg::REG_PTR)
		|=> (s_r.grp[$past(gi)].ptr == $past(apb_req.pwdata[ser_pkg::STAT_W-1:0])))
		else $error("rising filter write lost");
	a_ntr_write: assert property (
		(done && apb_req.pwrite && in_grp && off == ser_pkg::REG_NTR)
		|=> (s_r.grp[$past(gi)].ntr == $past(apb_req.pwdata[ser_pkg::STAT_W-1:0])))
		else $error("falling filter write lost");
	a_ena_write: assert property (
		(done && apb_req.pwrite && in_grp && off == ser_pkg::REG_ENA)
		|=> (s_r.grp[$past(gi)].ena == $past(apb_req.pwdata[ser_pkg::STAT_W-1:0])))
		else $error("enable mask write lost");

	// bus answer timing
	a_answer_wait: assert property (
		cap |=> apb_rsp.pready)
		else $error("answer not given one cycle after capture");
	a_pready_pulse: assert property (
		(apb_rsp.pready && apb_req.psel && apb_req.penable) |=> !apb_rsp.pready)
		else $error("ready stood longer than one cycle");
	a_slverr_zero: assert property (
		apb_rsp.pslverr |-> (apb_rsp.prdata == '0))
		else $error("error answer carried data");

	// preset leaves events and queue alone
	a_preset_evt_kept: assert property (
		preset_wr |=> (s_r.grp[0].evt == ($past(s_r.grp[0].evt) | $past(new_evt[0]))
			&& s_r.grp[1].evt == ($past(s_r.grp[1].evt) | $past(new_evt[1]))))
		else $error("preset touched an event part");
	a_preset_queue_kept: assert property (
		(preset_wr && !push_ok) |=> $stable(s_r.cnt))
		else $error("preset touched the error queue");
	a_parts_stable_b: assert property (
		!done |=> ($stable(s_r.grp[1].ptr) && $stable(s_r.grp[0].ntr)
			&& $stable(s_r.grp[0].ena)))
		else $error("status part changed without write or preset");

	// summaries
	a_oper_sum_low: assert property (
		((s_r.grp[0].evt & s_r.grp[0].ena) == '0) |=> !oper_sum)
		else $error("operation summary raised without enabled event");
	a_ques_sum_high: assert property (
		((s_r.grp[1].evt & s_r.grp[1].ena) != '0) |=> ques_sum)
		else $error("questionable summary not raised");
	a_sum_rise_cause: assert property (
		$rose(ques_sum) |-> $past((s_r.grp[1].evt & s_r.grp[1].ena) != '0))
		else $error("questionable summary rose without cause");

	// event read
	a_evt_read_data: assert property (
		(cap && !apb_req.pwrite && in_grp && off == ser_pkg::REG_EVT)
		|=> (apb_rsp.prdata[ser_pkg::STAT_W-1:0] == $past(s_r.grp[gi].evt)))
		else $error("event read returned wrong bits");
	a_evt_race_keep: assert property (
		(evt_rd && new_evt[gi] != '0)
		|=> ((s_r.grp[$past(gi)].evt & $past(new_evt[gi])) == $past(new_evt[gi])))
		else $error("event arriving during read was lost");

	// error queue
	a_queue_pop_data: assert property (
		(cap && !apb_req.pwrite && !in_grp && off == ser_pkg::REG_QUEUE
			&& s_r.cnt != ser_pkg::Q_EMPTY)
		|=> (apb_rsp.prdata[ser_pkg::CODE_W-1:0] == $past(s_r.q[s_r.rd]) && s_r.pop_pend))
		else $error("queue read not oldest entry");
	a_queue_rd_adv: assert property (
		pop |=> (s_r.rd == $past(s_r.rd) + ser_pkg::QPTR_ONE))
		else $error("queue read pointer did not advance");
	a_queue_push_count: assert property (
		(push_ok && !pop) |=> (s_r.cnt == $past(s_r.cnt) + ser_pkg::Q_ONE))
		else $error("queue push not counted");
	a_queue_full_drop: assert property (
		(err_push && s_r.cnt == ser_pkg::Q_FULL && !pop)
		|=> ($stable(s_r.cnt) && $stable(s_r.wr)))
		else $error("push into full queue not dropped");
	a_queue_bound: assert property (
		s_r.cnt <= ser_pkg::Q_FULL)
		else $error("queue count beyond depth");
	a_code_dev_pos: assert property (
		(push_ok && !err_std)
		|=> (s_r.q[$past(s_r.wr)] == {1'b0, $past(err_num)}))
		else $error("device error code not positive");
	a_code_std_neg: assert property (
		(push_ok && err_std)
		|=> ((s_r.q[$past(s_r.wr)] + {1'b0, $past(err_num)}) == ser_pkg::NO_ERROR))
		else $error("standard error code not negated");

	c_preset: cover property (preset_wr);
	c_read_race: cover property (evt_rd && new_evt[gi] != '0);
	c_queue_empty: cover property (cap && off == ser_pkg::REG_QUEUE && s_r.cnt == ser_pkg::Q_EMPTY);
	c_summary_rise: cover property (!ques_sum ##1 ques_sum);
	c_queue_pop: cover property (pop);
endmodule : ser_status_event_reporting

//--- tb/ser_ctrl_model.sv
/*
 * ser_ctrl_model: apb master standing in for the remote controller.
 * assumes: shares sys_clk with the block; the slave answers with pready.
 */
`timescale 1ns/1ps
module ser_ctrl_model (
	input wire logic sys_clk,
	output ser_pkg::ser_apb_req_s apb_req,
	input wire ser_pkg::ser_apb_rsp_s apb_rsp
);
	int unsigned hang_cnt;
	initial begin
		apb_req = '0;
		hang_cnt = 0;
	end
	// gap adds idle cycles so the controller can act slowly
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		input int gap, output logic [31:0] rdata, output logic err);
		int n;
		repeat (gap + 1) @(posedge sys_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= addr;
		apb_req.pwdata <= wdata;
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 16);
		if (n >= 16)
			hang_cnt++;
		rdata = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		// released lines stop showing the last value
		apb_req.paddr <= ~addr;
		apb_req.pwdata <= ~wdata;
	endtask : xfer
endmodule : ser_ctrl_model

//--- tb/test_status_event_reporting.sv
/*
 * test_status_event_reporting: directed bench for the status groups,
 * preset action and error queue.
 * assumes: ser_ctrl_model drives the apb side; cond and errors come from here.
 */
`timescale 1ns/1ps
module test_status_event_reporting;
	logic sys_clk;
	logic rst;
	ser_pkg::ser_apb_req_s apb_req;
	ser_pkg::ser_apb_rsp_s apb_rsp;
	ser_pkg::ser_stat_t cond;
	logic err_push;
	logic err_std;
	logic [14:0] err_num;
	logic oper_sum;
	logic ques_sum;
	logic [31:0] rdata;
	logic perr;
	int error_cnt = 0;
	int total_checks = 0;

	ser_status_event_reporting u_dut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .cond_in(cond), .err_push(err_push), .err_std(err_std),
		.err_num(err_num), .oper_sum(oper_sum), .ques_sum(ques_sum));
	ser_ctrl_model u_ctl (.sys_clk(sys_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] ra(input int g, input logic [7:0] r);
		return ((g != 0) ? ser_pkg::GRP_STRIDE : 8'h00) + r;
	endfunction : ra

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		u_ctl.xfer(1'b1, a, d, 0, rdata, perr);
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		u_ctl.xfer(1'b0, a, 32'h0, 1, rdata, perr);
		chk(rdata, exp);
	endtask : rchk

	task automatic setc(input int g, input logic [14:0] v);
		@(posedge sys_clk);
		cond[g] <= v;
		repeat (3) @(posedge sys_clk);
	endtask : setc

	task automatic push(input logic s, input logic [14:0] n);
		@(posedge sys_clk);
		err_push <= 1'b1;
		err_std <= s;
		err_num <= n;
		@(posedge sys_clk);
		err_push <= 1'b0;
	endtask : push

	task automatic t_reset();
		for (int g = 0; g < 2; g++) begin
			rchk(ra(g[0], ser_pkg::REG_PTR), 32'h7fff);
			rchk(ra(g[0], ser_pkg::REG_NTR), 32'h0);
			rchk(ra(g[0], ser_pkg::REG_ENA), 32'h0);
			rchk(ra(g[0], ser_pkg::REG_EVT), 32'h0);
		end
		chk({30'h0, oper_sum, ques_sum}, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_rise();
		wreg(ra(0, ser_pkg::REG_PTR), 32'h1);
		setc(0, 15'h0003);
		rchk(ra(0, ser_pkg::REG_EVT), 32'h1);
		rchk(ra(0, ser_pkg::REG_EVT), 32'h0);
		rchk(ra(0, ser_pkg::REG_COND), 32'h3);
		rchk(ra(0, ser_pkg::REG_COND), 32'h3);
		$display("test rise done");
	endtask : t_rise

	task automatic t_fall();
		setc(1, 15'h0006);
		rchk(ra(1, ser_pkg::REG_EVT), 32'h6);
		setc(1, 15'h0004);
		rchk(ra(1, ser_pkg::REG_EVT), 32'h0);
		wreg(ra(1, ser_pkg::REG_NTR), 32'h4);
		setc(1, 15'h0000);
		rchk(ra(1, ser_pkg::REG_EVT), 32'h4);
		wreg(ra(1, ser_pkg::REG_PTR), 32'hffffffff);
		rchk(ra(1, ser_pkg::REG_PTR), 32'h7fff);
		setc(1, 15'h7fff);
		rchk(ra(1, ser_pkg::REG_EVT), 32'h7fff);
		$display("test fall done");
	endtask : t_fall

	task automatic t_sum();
		wreg(ra(1, ser_pkg::REG_ENA), 32'h10);
		wreg(ra(0, ser_pkg::REG_ENA), 32'h1);
		setc(1, 15'h7fef);
		setc(1, 15'h7fff);
		chk({30'h0, oper_sum, ques_sum}, 32'h1);
		setc(0, 15'h0002);
		setc(0, 15'h0003);
		chk({30'h0, oper_sum, ques_sum}, 32'h3);
		rchk(ra(1, ser_pkg::REG_EVT), 32'h10);
		rchk(ra(0, ser_pkg::REG_EVT), 32'h1);
		repeat (3) @(posedge sys_clk);
		chk({30'h0, oper_sum, ques_sum}, 32'h0);
		$display("test summary done");
	endtask : t_sum

	task automatic t_preset();
		wreg(ser_pkg::REG_PRESET, 32'h0);
		for (int g = 0; g < 2; g++) begin
			rchk(ra(g[0], ser_pkg::REG_PTR), 32'h7fff);
			rchk(ra(g[0], ser_pkg::REG_NTR), 32'h0);
			rchk(ra(g[0], ser_pkg::REG_ENA), 32'h0);
		end
		$display("test preset done");
	endtask : t_preset

	task automatic t_queue();
		rchk(ser_pkg::REG_QUEUE, 32'h0);
		push(1'b0, 15'h0005);
		push(1'b1, 15'h0003);
		rchk(ser_pkg::REG_QCOUNT, 32'h2);
		rchk(ser_pkg::REG_QUEUE, 32'h5);
		rchk(ser_pkg::REG_QUEUE, 32'hfffffffd);
		rchk(ser_pkg::REG_QUEUE, 32'h0);
		rchk(8'h80, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test queue done");
	endtask : t_queue

	task automatic close_out();
		error_cnt += int'(u_ctl.hang_cnt);
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		cond = '0;
		err_push = 1'b0;
		err_std = 1'b0;
		err_num = '0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_rise();
		t_fall();
		t_sum();
		t_preset();
		t_queue();
		close_out();
	end
endmodule : test_status_event_reporting
